/* logic/msc_pkg.sv */
// Constants for the module-stop clock gating block.
// Assumes a 32-bit AXI4-Lite register bus with small local byte addresses.
package msc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned MSC_ADDR_W = 4;
  localparam logic [3:0] MSC_OFS_CTRL_A = 4'h0;
  localparam logic [3:0] MSC_OFS_CTRL_B = 4'h4;
  localparam logic [3:0] MSC_OFS_CTRL_C = 4'h8;

  // Writable bits, bits fixed at one, and reset values of each register
  localparam logic [7:0] MSC_A_WR_MASK = 8'hBD;
  localparam logic [7:0] MSC_A_FIXED_ONE = 8'h42;
  localparam logic [7:0] MSC_A_RESET = 8'hFF;
  localparam logic [7:0] MSC_B_WR_MASK = 8'hF8;
  localparam logic [7:0] MSC_B_FIXED_ONE = 8'h07;
  localparam logic [7:0] MSC_B_RESET = 8'hFF;
  localparam logic [7:0] MSC_C_WR_MASK = 8'h03;
  localparam logic [7:0] MSC_C_FIXED_ONE = 8'h00;
  localparam logic [7:0] MSC_C_RESET = 8'h03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MSC_A_I2C2_BIT = 7;
  localparam int unsigned MSC_A_SERIAL2_BIT = 5;
  localparam int unsigned MSC_A_SERIAL1_BIT = 4;
  localparam int unsigned MSC_A_SERIAL0_BIT = 3;
  localparam int unsigned MSC_A_SYNC_BIT = 2;
  localparam int unsigned MSC_A_CAN0_BIT = 0;
  localparam int unsigned MSC_B_TIMER_S_BIT = 7;
  localparam int unsigned MSC_B_TIMER_BIT = 6;
  localparam int unsigned MSC_B_CMT_BIT = 5;
  localparam int unsigned MSC_B_ADC1_BIT = 4;
  localparam int unsigned MSC_B_ADC0_BIT = 3;
  localparam int unsigned MSC_C_TRACE_BIT = 1;
  localparam int unsigned MSC_C_BREAK_BIT = 0;

  // ----------------------------------------------------------------
  // Gated module index on the clock outputs
  // ----------------------------------------------------------------
  localparam int unsigned MSC_NUM_MOD = 13;
  localparam int unsigned MSC_IDX_I2C2 = 0;
  localparam int unsigned MSC_IDX_SERIAL2 = 1;
  localparam int unsigned MSC_IDX_SERIAL1 = 2;
  localparam int unsigned MSC_IDX_SERIAL0 = 3;
  localparam int unsigned MSC_IDX_SYNC = 4;
  localparam int unsigned MSC_IDX_CAN0 = 5;
  localparam int unsigned MSC_IDX_TIMER_S = 6;
  localparam int unsigned MSC_IDX_TIMER = 7;
  localparam int unsigned MSC_IDX_CMT = 8;
  localparam int unsigned MSC_IDX_ADC1 = 9;
  localparam int unsigned MSC_IDX_ADC0 = 10;
  localparam int unsigned MSC_IDX_TRACE = 11;
  localparam int unsigned MSC_IDX_BREAK = 12;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] MSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] MSC_RESP_SLVERR = 2'h2;

endpackage

/* logic/msc_clk_gate.sv */
// One glitch-free clock gate for a single peripheral module.
// Assumes a free-running source clock and an enable synchronous to it.
`timescale 1ns/1ps
`default_nettype none

module msc_clk_gate (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic stop_in,
  output logic gated_clk_out
);

  logic run_q;

  // ----------------------------------------------------------------
  // Enable held on the low phase
  // ----------------------------------------------------------------
  // glitch-free gating
  // Enable only moves while the clock is low, so only the asynchronous reset can cut a pulse.
  always_ff @(negedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_q <= 1'b0;
    end else begin
      run_q <= ~stop_in;
    end
  end

  assign gated_clk_out = clock_in & run_q;

endmodule

`default_nettype wire

/* logic/msc_module_stop.sv */
// Module-stop registers and per-module clock gates behind an AXI4-Lite slave.
// Assumes one 125 MHz peripheral clock and an AXI4-Lite master on that clock.
//
// Summary of operation
// - Control A bit 7 stops I2C channel two
// - Control A bit 5 stops serial channel two
// - Control A bit 4 stops serial channel one
// - Control A bit 3 stops serial channel zero
// - Control A bit 2 stops sync serial unit
// - Control A bit 0 stops CAN controller zero
// - Control A bits 6,1 read one, fixed
// - Control B bit 7 stops secondary timer unit
// - Control B bit 6 stops primary timer unit
// - Control B bit 5 stops compare match timer
// - Control B bits 4,3 stop both converters
// - Control B bits 2..0 read one, fixed
// - Control C bit 1 stops debug trace unit
// - Control C bit 0 stops break controller
// - Control C bits 7..2 read zero, fixed
`timescale 1ns/1ps
`default_nettype none

module msc_module_stop
  import msc_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [MSC_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [MSC_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [MSC_NUM_MOD-1:0] stop_out,
  output logic [MSC_NUM_MOD-1:0] gated_clk_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] ctrl_c_q;
  logic awready_q;
  logic wready_q;
  logic aw_got_q;
  logic w_got_q;
  logic [MSC_ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire aw_hs = s_axi_awvalid_in & awready_q;
  wire w_hs = s_axi_wvalid_in & wready_q;
  wire b_hs = bvalid_q & s_axi_bready_in;
  wire wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  wire wr_hit_a = aw_addr_q == MSC_OFS_CTRL_A;
  wire wr_hit_b = aw_addr_q == MSC_OFS_CTRL_B;
  wire wr_hit_c = aw_addr_q == MSC_OFS_CTRL_C;
  wire wr_mapped = wr_hit_a | wr_hit_b | wr_hit_c;
  wire wr_a = wr_fire & w_lane_q & wr_hit_a;
  wire wr_b = wr_fire & w_lane_q & wr_hit_b;
  wire wr_c = wr_fire & w_lane_q & wr_hit_c;

  // Writes never store reserved bits; they are forced on read instead
  wire [7:0] ctrl_a_d = wr_a ? (w_byte_q & MSC_A_WR_MASK) : ctrl_a_q;
  wire [7:0] ctrl_b_d = wr_b ? (w_byte_q & MSC_B_WR_MASK) : ctrl_b_q;
  wire [7:0] ctrl_c_d = wr_c ? (w_byte_q & MSC_C_WR_MASK) : ctrl_c_q;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  wire ar_hs = s_axi_arvalid_in & arready_q;
  wire r_hs = rvalid_q & s_axi_rready_in;
  wire rd_hit_a = s_axi_araddr_in == MSC_OFS_CTRL_A;
  wire rd_hit_b = s_axi_araddr_in == MSC_OFS_CTRL_B;
  wire rd_hit_c = s_axi_araddr_in == MSC_OFS_CTRL_C;
  wire rd_mapped = rd_hit_a | rd_hit_b | rd_hit_c;
  wire [7:0] view_a = (ctrl_a_q & MSC_A_WR_MASK) | MSC_A_FIXED_ONE;
  wire [7:0] view_b = (ctrl_b_q & MSC_B_WR_MASK) | MSC_B_FIXED_ONE;
  wire [7:0] view_c = (ctrl_c_q & MSC_C_WR_MASK) | MSC_C_FIXED_ONE;
  wire [7:0] rd_byte = rd_hit_a ? view_a :
                       rd_hit_b ? view_b :
                       rd_hit_c ? view_c : 8'h00;

  // ----------------------------------------------------------------
  // Stop registers
  // ----------------------------------------------------------------
  // all modules stopped at reset
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_a_q <= MSC_A_RESET;
      ctrl_b_q <= MSC_B_RESET;
      ctrl_c_q <= MSC_C_RESET;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      ctrl_c_q <= ctrl_c_d;
    end
  end

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      awready_q <= 1'b1;
      aw_got_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (aw_hs) begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end else if (b_hs) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wready_q <= 1'b1;
      w_got_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (w_hs) begin
      wready_q <= 1'b0;
      w_got_q <= 1'b1;
      w_byte_q <= s_axi_wdata_in[7:0];
      w_lane_q <= s_axi_wstrb_in[0];
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end else if (b_hs) begin
      wready_q <= 1'b1;
    end
  end

  // Unmapped addresses answer with a slave error and change nothing
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= MSC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= MSC_RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_mapped ? MSC_RESP_OKAY : MSC_RESP_SLVERR;
    end else if (r_hs) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // ----------------------------------------------------------------
  // Stop vector and gates
  // ----------------------------------------------------------------
  logic [MSC_NUM_MOD-1:0] stop_vec;
  assign stop_vec[MSC_IDX_I2C2] = ctrl_a_q[MSC_A_I2C2_BIT];
  assign stop_vec[MSC_IDX_SERIAL2] = ctrl_a_q[MSC_A_SERIAL2_BIT];
  assign stop_vec[MSC_IDX_SERIAL1] = ctrl_a_q[MSC_A_SERIAL1_BIT];
  assign stop_vec[MSC_IDX_SERIAL0] = ctrl_a_q[MSC_A_SERIAL0_BIT];
  assign stop_vec[MSC_IDX_SYNC] = ctrl_a_q[MSC_A_SYNC_BIT];
  assign stop_vec[MSC_IDX_CAN0] = ctrl_a_q[MSC_A_CAN0_BIT];
  assign stop_vec[MSC_IDX_TIMER_S] = ctrl_b_q[MSC_B_TIMER_S_BIT];
  assign stop_vec[MSC_IDX_TIMER] = ctrl_b_q[MSC_B_TIMER_BIT];
  assign stop_vec[MSC_IDX_CMT] = ctrl_b_q[MSC_B_CMT_BIT];
  assign stop_vec[MSC_IDX_ADC1] = ctrl_b_q[MSC_B_ADC1_BIT];
  assign stop_vec[MSC_IDX_ADC0] = ctrl_b_q[MSC_B_ADC0_BIT];
  assign stop_vec[MSC_IDX_TRACE] = ctrl_c_q[MSC_C_TRACE_BIT];
  assign stop_vec[MSC_IDX_BREAK] = ctrl_c_q[MSC_C_BREAK_BIT];
  assign stop_out = stop_vec;

  // one clean gate each
  // Every gate, the trace unit's included, is held shut while nrst_in is low; software can open one only after reset is released.
  for (genvar g = 0; g < MSC_NUM_MOD; g++) begin : gen_gate
    msc_clk_gate u_gate (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .stop_in(stop_vec[g]),
      .gated_clk_out(gated_clk_out[g])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_I2C2_FOLLOWS_WRITE: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    wr_a |=> stop_out[MSC_IDX_I2C2] == $past(w_byte_q[7]))
    else $error("I2C two stop bit did not follow write");

  AST_SERIAL_FOLLOWS_WRITE: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    wr_a |=> {stop_out[MSC_IDX_SERIAL2], stop_out[MSC_IDX_SERIAL1], stop_out[MSC_IDX_SERIAL0]}
      == $past(w_byte_q[5:3]))
    else $error("Serial stop bits did not follow write");

  AST_CAN_SYNC_FOLLOW: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    wr_a |=> stop_out[MSC_IDX_SYNC] == $past(w_byte_q[2])
      && stop_out[MSC_IDX_CAN0] == $past(w_byte_q[0]))
    else $error("Sync serial or CAN stop bit wrong after write");

  AST_A_FIXED_ONES: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    ar_hs && rd_hit_a |=> rvalid_q && rdata_q[6] && rdata_q[1] && rdata_q[31:8] == 24'h00_0000)
    else $error("Control A reserved bits not read as one");

  AST_TIMERS_FOLLOW: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    wr_b |=> {stop_out[MSC_IDX_TIMER_S], stop_out[MSC_IDX_TIMER], stop_out[MSC_IDX_CMT],
      stop_out[MSC_IDX_ADC1], stop_out[MSC_IDX_ADC0]} == $past(w_byte_q[7:3]))
    else $error("Control B stop bits did not follow write");

  AST_B_FIXED_ONES: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    ar_hs && rd_hit_b |=> rdata_q[2:0] == 3'h7)
    else $error("Control B reserved bits not read as one");

  AST_C_FOLLOWS_WRITE: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    wr_c |=> {stop_out[MSC_IDX_TRACE], stop_out[MSC_IDX_BREAK]} == $past(w_byte_q[1:0]))
    else $error("Control C stop bits did not follow write");

  AST_C_RESERVED_ZERO: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    ar_hs && rd_hit_c |=> rdata_q[7:2] == 6'h00)
    else $error("Control C reserved bits not read as zero");

  AST_STOP_HOLDS: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    !(wr_a || wr_b || wr_c) |=> $stable(stop_out))
    else $error("Stop bits changed without a register write");

  AST_WRITE_ANSWERED: assert property (
    @(posedge clock_in) disable iff (!nrst_in)
    aw_got_q && w_got_q && !bvalid_q |=>
      bvalid_q && ((bresp_q == MSC_RESP_OKAY) == $past(wr_mapped)))
    else $error("Write not answered one cycle after both halves held");

  AST_RESET_STOPS_ALL: assert property (
    @(negedge clock_in)
    $rose(nrst_in) |-> stop_out == {MSC_NUM_MOD{1'b1}} && gated_clk_out == '0)
    else $error("Module clocks not stopped coming out of reset");

endmodule

`default_nettype wire

/* sim/msc_periph_model.sv */
// Stand-in for the gated peripherals: counts clock pulses per module.
// Assumes gated clocks whose high phase is half a 125 MHz period.
`timescale 1ns/1ps
`default_nettype none

module msc_periph_model
  import msc_pkg::*;
(
  input wire logic [MSC_NUM_MOD-1:0] gated_clk_in,
  output int pulse_cnt_out [MSC_NUM_MOD],
  output int glitch_cnt_out
);
  // ----------------------------------------------------------------
  // Pulse counting
  // ----------------------------------------------------------------
  int cnt [MSC_NUM_MOD] = '{default: 0};
  int glitches = 0;
  realtime rise_t [MSC_NUM_MOD];
  logic [MSC_NUM_MOD-1:0] prev = '0;

  // short pulse watch
  // A truncated high phase would upset a real peripheral's flops
  always @(gated_clk_in) begin
    for (int i = 0; i < MSC_NUM_MOD; i++) begin
      if (gated_clk_in[i] === 1'b1 && prev[i] !== 1'b1) begin
        cnt[i] = cnt[i] + 1;
        rise_t[i] = $realtime;
      end else if (gated_clk_in[i] !== 1'b1 && prev[i] === 1'b1) begin
        if ($realtime - rise_t[i] < 3.5) glitches = glitches + 1;
      end
    end
    prev = gated_clk_in;
  end

  assign pulse_cnt_out = cnt;
  assign glitch_cnt_out = glitches;
endmodule

`default_nettype wire

/* sim/tb_msc_module_stop.sv */
// Self-checking bench for the module-stop block over AXI4-Lite.
// Assumes the peripheral model counts gated clock pulses.
`timescale 1ns/1ps
`default_nettype none

module tb_msc_module_stop;
  import msc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [MSC_NUM_MOD-1:0] stop, gclk;
  int pcnt [MSC_NUM_MOD];
  int glitch;
  int err_total = 0;
  int n_checks = 0;

  always #4 clk = ~clk;

  msc_module_stop uut (.clock_in(clk), .nrst_in(nrst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .stop_out(stop), .gated_clk_out(gclk));

  msc_periph_model periph (.gated_clk_in(gclk), .pulse_cnt_out(pcnt), .glitch_cnt_out(glitch));

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic timed_out(input logic hung);
    if (hung) begin
      chk(32'h0, 32'h1, "bus handshake timeout");
      conclude();
    end
  endtask

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    r = bresp;
    bready <= 1'b0;
    timed_out(bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    timed_out(rvalid !== 1'b1);
  endtask

  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp);
    logic [1:0] r;
    logic [31:0] v;
    wr(a, d, r);
    chk({30'h0, r}, 32'h0, "write response");
    rd(a, v, r);
    chk(v, {24'h0, exp}, "read back");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [1:0] r;
    logic [31:0] v;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    // Look in the high phase, where a leaking gate would show
    #2;
    chk({19'h0, stop}, 32'h1FFF, "stops in reset");
    chk({19'h0, gclk}, 32'h0, "clocks low in reset");
    @(posedge clk);
    nrst <= 1'b1;
    rd(4'h0, v, r);
    chk(v, 32'hFF, "control A reset value");
    rd(4'h4, v, r);
    chk(v, 32'hFF, "control B reset value");
    rd(4'h8, v, r);
    chk(v, 32'h03, "control C reset value");
    $display("test reset done");
  endtask

  task automatic t_gates;
    logic [3:0] ofs [13] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h4, 4'h4,
      4'h4, 4'h8, 4'h8};
    int bitpos [13] = '{7, 5, 4, 3, 2, 0, 7, 6, 5, 4, 3, 1, 0};
    int snap [MSC_NUM_MOD];
    logic [7:0] rv;
    for (int i = 0; i < MSC_NUM_MOD; i++) begin
      rv = (ofs[i] == 4'h8) ? 8'h03 : 8'hFF;
      // with reset released, clear one module's stop bit; only that module's clock should pulse
      wr_rd(ofs[i], rv & ~(8'h01 << bitpos[i]), rv & ~(8'h01 << bitpos[i]));
      chk({19'h0, stop}, 32'h1FFF & ~(32'h1 << i), "single stop cleared");
      repeat (2) @(negedge clk);
      snap = pcnt;
      repeat (10) @(negedge clk);
      for (int j = 0; j < MSC_NUM_MOD; j++) begin
        chk(pcnt[j] - snap[j], (j == i) ? 10 : 0, "gated pulses");
      end
      wr_rd(ofs[i], rv, rv);
      chk({19'h0, stop}, 32'h1FFF, "stop restored");
    end
    $display("test gates done");
  endtask

  task automatic t_fixed_bits;
    logic [1:0] r;
    logic [31:0] v;
    wr_rd(4'h0, 8'h00, 8'h42);
    wr_rd(4'h4, 8'h00, 8'h07);
    wr_rd(4'h8, 8'hFF, 8'h03);
    wr_rd(4'h8, 8'h00, 8'h00);
    // Byte lane zero off: the write is answered but stores nothing
    wstrb <= 4'hE;
    wr(4'h0, 8'hFF, r);
    wstrb <= 4'hF;
    chk({30'h0, r}, 32'h0, "lane-off write response");
    rd(4'h0, v, r);
    chk(v, 32'h42, "lane-off write ignored");
    chk({19'h0, stop}, 32'h0, "all clocks running");
    wr(4'hC, 8'h00, r);
    chk({30'h0, r}, 32'h2, "unmapped write error");
    rd(4'hC, v, r);
    chk({30'h0, r}, 32'h2, "unmapped read error");
    chk(v, 32'h0, "unmapped read data");
    $display("test fixed bits done");
  endtask

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_gates();
    t_fixed_bits();
    // A reset cuts a running gated clock short, so the pulse check closes before it
    chk(glitch, 0, "no truncated pulses");
    t_reset();
    conclude();
  end
endmodule

`default_nettype wire
